/* tbmc_pins.sv */
// Far-side model: capture sources, timer clock pin, output wire
`timescale 1ns/1ps
module tbmc_pins (
	input  wire logic pclk,
	input  wire logic timer_output_pin,
	input  wire logic timer_output_en,
	output logic      capture_input_pin,
	output logic      internal_detector_output,
	output logic      timer_clock_pin,
	output logic      out_wire
);
	// Pull-up holds the wire when undriven
	assign out_wire = timer_output_en ? timer_output_pin : 1'b1;
	initial begin
		capture_input_pin = 1'b0;
		internal_detector_output = 1'b0;
		timer_clock_pin = 1'b0;
	end
	task automatic drive(input logic src, input logic lvl);
		@(posedge pclk);
		if (src) internal_detector_output <= lvl;
		else capture_input_pin <= lvl;
	endtask
endmodule

/* tbmc_pkg.sv */
// Package for the ten-bit timer: register map, field layouts, reset values and modes
package tbmc_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_CONTROL0    = 8'h00;
	localparam logic [7:0] OFS_MODE_CTRL   = 8'h04;
	localparam logic [7:0] OFS_COUNT_LOW   = 8'h08;
	localparam logic [7:0] OFS_COUNT_HIGH  = 8'h0C;
	localparam logic [7:0] OFS_CMPA_LOW    = 8'h10;
	localparam logic [7:0] OFS_CMPA_HIGH   = 8'h14;
	localparam logic [7:0] OFS_CAP_SEL     = 8'h18;
	localparam logic [7:0] OFS_FLAGS       = 8'h1C;

	// Values after reset
	localparam logic [7:0] RST_CONTROL0    = 8'h00;
	localparam logic [7:0] RST_MODE_CTRL   = 8'h00;
	localparam logic [9:0] RST_CMPA        = 10'h000;
	localparam logic [9:0] RST_COUNT       = 10'h000;

	// Field positions
	localparam int         CAP_SEL_BIT     = 7;
	localparam int         FLAG_A_BIT      = 0;
	localparam int         FLAG_P_BIT      = 1;
	localparam int         P_SHIFT         = 7;

	// Counter lengths
	localparam logic [10:0] FULL_LEN       = 11'h400;

	// Timer clock prescale counts
	localparam logic [5:0] DIV4_MASK       = 6'h03;
	localparam logic [5:0] DIV16_MASK      = 6'h0F;
	localparam logic [5:0] DIV64_MASK      = 6'h3F;

	typedef enum logic [1:0] {
		MODE_COMPARE,
		MODE_CAPTURE,
		MODE_PWM,
		MODE_TIMER
	} tbmc_mode_e;

	typedef enum logic [2:0] {
		CLK_DIV4,
		CLK_DIV1,
		CLK_DIV16,
		CLK_DIV64,
		CLK_SUB_A,
		CLK_SUB_B,
		CLK_PIN_RISE,
		CLK_PIN_FALL
	} tbmc_clk_e;

	// First control register: pause, clock, enable, compare-P
	typedef struct packed {
		logic       pause;
		tbmc_clk_e  clk_sel;
		logic       counter_on;
		logic [2:0] compare_p_value;
	} tbmc_ctrl0_s;

	// Mode and output control register
	typedef struct packed {
		tbmc_mode_e mode_select;
		logic [1:0] pin_function;
		logic       output_initial_level;
		logic       output_invert;
		logic       duty_period_swap;
		logic       clear_source;
	} tbmc_mode_s;

endpackage

/* tbmc_timer.sv */
// Ten-bit up-counting timer with compare, PWM, single pulse and capture modes on APB
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1 - Mode field: 00 compare output, 01 capture, 10 PWM/single pulse, 11 timer.
// R2 - Software stops the counter before changing the mode field.
// R3 - Compare mode on A match: nothing, low, high or toggle per pin function.
// R4 - PWM mode pin function: inactive, active, PWM waveform, single pulse.
// R5 - Capture mode pin function: rising, falling, both edges, or disabled.
// R6 - Software changes pin function in PWM mode only while stopped.
// R7 - Compare mode: pin takes initial level when counter_on rises.
// R8 - Initial level sets PWM polarity and single-pulse level at start.
// R9 - Output invert set inverts the output pin.
// R10 - Timer mode: pin undefined, level, invert and pin function unused.
// R11 - Swap 0: compare-P period, A duty; swap 1 the reverse.
// R12 - Clear source 1 clears on A; 0 clears on P or overflow.
// R13 - Clear source ignored in PWM, single pulse and capture modes.
// R14 - Counter readable as low byte and two-bit high byte, rest zero.
// R15 - Compare-A readable and writable as low byte plus two high bits.
// R16 - Capture source select: 0 external pin, 1 internal detector.
// R17 - Compare mode, clear source 0: both A and P flags raised.
// R18 - Compare mode, clear source 1: only A flag, never P flag.
// R19 - Compare-A zero: counter overflows at 3FF without A flag.
// R20 - Compare mode: pin changes only on A match, never on P.
// R21 - Counter cleared on counter_on rising, kept on falling.
// R22 - Compare-P compared with counter bits 9..7; zero means 1024 clocks.
// R23 - Low-byte write buffers, high write commits; high read latches low.
module tbmc_timer #(
	parameter int SUB_DIV = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_input_pin,
	input  wire logic        internal_detector_output,
	input  wire logic        timer_clock_pin,
	output logic             timer_output_pin,
	output logic             timer_output_en
);

	tbmc_pkg::tbmc_ctrl0_s ctrl0_r;
	tbmc_pkg::tbmc_mode_s  mode_r;
	logic                  cap_sel_r;
	logic [9:0]            cnt_r;
	logic [9:0]            cnt_nxt;
	logic [9:0]            cmpa_r;
	logic [7:0]            buf_r;
	logic                  flag_a_r;
	logic                  flag_p_r;
	logic                  on_q_r;
	logic                  on_rise;
	logic [31:0]           prdata_r;
	logic [31:0]           rdata;
	logic                  rd_ok;
	logic                  wr_acc;
	logic                  rd_acc;
	logic                  setup_rd;
	logic [5:0]            pre_r;
	logic [15:0]           sub_r;
	logic                  tick;
	logic                  adv;
	logic [10:0]           cnt_inc;
	logic [10:0]           p_len;
	logic [10:0]           duty;
	logic                  match_a;
	logic                  match_p;
	logic                  clr;
	logic                  set_a;
	logic                  set_p;
	logic                  pin_r;
	logic                  pin_nxt;
	logic                  out_r;
	logic                  oen_r;
	logic                  pwm_lvl;
	logic                  single;
	logic                  hw_stop;
	logic                  cap_s1_r;
	logic                  cap_s2_r;
	logic                  cap_s3_r;
	logic                  cap_lvl_r;
	logic                  cap_rise;
	logic                  cap_fall;
	logic                  cap_evt;
	logic                  ck_s1_r;
	logic                  ck_s2_r;
	logic                  ck_s3_r;
	logic                  ck_lvl_r;
	logic                  ck_edge;

	//////////////////////////////////////////////////////////////////////////////////////////
	// APB slave
	assign wr_acc   = psel & penable & pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~rd_ok;
	assign prdata   = prdata_r;

	always_comb begin
		rdata = 32'h0000_0000;
		rd_ok = 1'b1;
		if (paddr == tbmc_pkg::OFS_CONTROL0) begin
			rdata[7:0] = ctrl0_r;
		end else if (paddr == tbmc_pkg::OFS_MODE_CTRL) begin
			rdata[7:0] = mode_r;
		end else if (paddr == tbmc_pkg::OFS_COUNT_LOW || paddr == tbmc_pkg::OFS_CMPA_LOW) begin
			rdata[7:0] = buf_r; // see R23
		end else if (paddr == tbmc_pkg::OFS_COUNT_HIGH) begin
			rdata[1:0] = cnt_r[9:8]; // see R14
		end else if (paddr == tbmc_pkg::OFS_CMPA_HIGH) begin
			rdata[1:0] = cmpa_r[9:8]; // see R15
		end else if (paddr == tbmc_pkg::OFS_CAP_SEL) begin
			rdata[tbmc_pkg::CAP_SEL_BIT] = cap_sel_r;
		end else if (paddr == tbmc_pkg::OFS_FLAGS) begin
			rdata[tbmc_pkg::FLAG_A_BIT] = flag_a_r;
			rdata[tbmc_pkg::FLAG_P_BIT] = flag_p_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read data captured in the setup cycle, shown through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_rd) begin
			prdata_r <= rdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_r <= tbmc_pkg::RST_CONTROL0;
		end else if (wr_acc && paddr == tbmc_pkg::OFS_CONTROL0) begin
			ctrl0_r <= pwdata[7:0];
		end else if (hw_stop) begin
			ctrl0_r.counter_on <= 1'b0;
		end else if (single && ck_edge && !ctrl0_r.counter_on) begin
			ctrl0_r.counter_on <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r    <= tbmc_pkg::RST_MODE_CTRL;
			cap_sel_r <= 1'b0;
		end else if (wr_acc && paddr == tbmc_pkg::OFS_MODE_CTRL) begin
			mode_r <= pwdata[7:0]; // see R1
		end else if (wr_acc && paddr == tbmc_pkg::OFS_CAP_SEL) begin
			cap_sel_r <= pwdata[tbmc_pkg::CAP_SEL_BIT]; // see R16
		end
	end

	// Shared byte buffer for split low/high access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_r <= 8'h00;
		end else if (wr_acc && paddr == tbmc_pkg::OFS_CMPA_LOW) begin
			buf_r <= pwdata[7:0]; // see R23
		end else if (rd_acc && paddr == tbmc_pkg::OFS_COUNT_HIGH) begin
			buf_r <= cnt_r[7:0]; // see R23
		end else if (rd_acc && paddr == tbmc_pkg::OFS_CMPA_HIGH) begin
			buf_r <= cmpa_r[7:0]; // see R23
		end
	end

	// Compare-A: committed by high write, overwritten by a capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpa_r <= tbmc_pkg::RST_CMPA;
		end else if (cap_evt) begin
			cmpa_r <= cnt_r;
		end else if (wr_acc && paddr == tbmc_pkg::OFS_CMPA_HIGH) begin
			cmpa_r <= {pwdata[1:0], buf_r}; // see R15, R23
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_s1_r  <= 1'b0;
			cap_s2_r  <= 1'b0;
			cap_s3_r  <= 1'b0;
			cap_lvl_r <= 1'b0;
			ck_s1_r   <= 1'b0;
			ck_s2_r   <= 1'b0;
			ck_s3_r   <= 1'b0;
			ck_lvl_r  <= 1'b0;
		end else begin
			cap_s1_r <= cap_sel_r ? internal_detector_output : capture_input_pin; // see R16
			cap_s2_r <= cap_s1_r;
			cap_s3_r <= cap_s2_r;
			ck_s1_r  <= timer_clock_pin;
			ck_s2_r  <= ck_s1_r;
			ck_s3_r  <= ck_s2_r;
			if (cap_s2_r == cap_s3_r) begin
				cap_lvl_r <= cap_s3_r;
			end
			if (ck_s2_r == ck_s3_r) begin
				ck_lvl_r <= ck_s3_r;
			end
		end
	end

	assign cap_rise = (cap_s2_r == cap_s3_r) & cap_s3_r & ~cap_lvl_r;
	assign cap_fall = (cap_s2_r == cap_s3_r) & ~cap_s3_r & cap_lvl_r;
	assign ck_edge  = (ck_s2_r == ck_s3_r) & (ck_s3_r != ck_lvl_r) &
	                  (ck_s3_r ^ (ctrl0_r.clk_sel == tbmc_pkg::CLK_PIN_FALL));

	//////////////////////////////////////////////////////////////////////////////////////////
	// Timer clock enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 6'h00;
			sub_r <= 16'h0000;
		end else begin
			pre_r <= pre_r + 6'h01;
			if (sub_r >= 16'(SUB_DIV - 1)) begin
				sub_r <= 16'h0000;
			end else begin
				sub_r <= sub_r + 16'h0001;
			end
		end
	end

	always_comb begin
		case (ctrl0_r.clk_sel)
			tbmc_pkg::CLK_DIV4:     tick = (pre_r & tbmc_pkg::DIV4_MASK) == tbmc_pkg::DIV4_MASK;
			tbmc_pkg::CLK_DIV1:     tick = 1'b1;
			tbmc_pkg::CLK_DIV16:    tick = (pre_r & tbmc_pkg::DIV16_MASK) == tbmc_pkg::DIV16_MASK;
			tbmc_pkg::CLK_DIV64:    tick = pre_r == tbmc_pkg::DIV64_MASK;
			tbmc_pkg::CLK_SUB_A,
			tbmc_pkg::CLK_SUB_B:    tick = sub_r == 16'h0000;
			default:                tick = ck_edge;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Counter, compare and flags
	assign single  = (mode_r.mode_select == tbmc_pkg::MODE_PWM) && (mode_r.pin_function == 2'b11);
	assign on_rise = ctrl0_r.counter_on & ~on_q_r;
	assign adv     = ctrl0_r.counter_on & ~ctrl0_r.pause & tick & ~on_rise;
	assign cnt_inc = {1'b0, cnt_r} + 11'h001;
	// Zero compare-P gives the full 1024-count length
	assign p_len   = (ctrl0_r.compare_p_value == 3'h0) ? tbmc_pkg::FULL_LEN :
	                 {1'b0, ctrl0_r.compare_p_value, 7'h00}; // see R22
	assign match_p = adv & (cnt_inc == p_len); // see R22
	assign match_a = adv & (cmpa_r != 10'h000) & (cnt_inc == {1'b0, cmpa_r}); // see R19
	assign duty    = mode_r.duty_period_swap ? p_len : {1'b0, cmpa_r}; // see R11
	assign hw_stop = single & match_a;

	always_comb begin
		clr   = 1'b0;
		set_a = 1'b0;
		set_p = 1'b0;
		case (mode_r.mode_select)
			tbmc_pkg::MODE_COMPARE,
			tbmc_pkg::MODE_TIMER: begin
				clr   = mode_r.clear_source ? match_a : match_p; // see R12
				set_a = match_a; // see R17, R19
				set_p = match_p & ~mode_r.clear_source; // see R17, R18
			end
			tbmc_pkg::MODE_CAPTURE: begin
				clr   = match_p; // see R13
				set_a = cap_evt;
				set_p = match_p;
			end
			default: begin
				clr   = single ? 1'b0 : (mode_r.duty_period_swap ? match_a : match_p); // see R11, R13
				set_a = match_a;
				set_p = single ? 1'b0 : match_p;
			end
		endcase
	end

	always_comb begin
		cap_evt = 1'b0;
		if (mode_r.mode_select == tbmc_pkg::MODE_CAPTURE && ctrl0_r.counter_on) begin
			case (mode_r.pin_function)
				2'b00:   cap_evt = cap_rise; // see R5
				2'b01:   cap_evt = cap_fall; // see R5
				2'b10:   cap_evt = cap_rise | cap_fall; // see R5
				default: cap_evt = 1'b0; // see R5
			endcase
		end
	end

	always_comb begin
		cnt_nxt = cnt_r;
		if (on_rise) begin
			cnt_nxt = tbmc_pkg::RST_COUNT; // see R21
		end else if (clr) begin
			cnt_nxt = tbmc_pkg::RST_COUNT; // see R12
		end else if (adv) begin
			cnt_nxt = cnt_inc[9:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= tbmc_pkg::RST_COUNT;
			on_q_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt; // see R21
			on_q_r <= ctrl0_r.counter_on;
		end
	end

	// Sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_a_r <= 1'b0;
			flag_p_r <= 1'b0;
		end else begin
			if (set_a) begin
				flag_a_r <= 1'b1;
			end else if (wr_acc && paddr == tbmc_pkg::OFS_FLAGS && pwdata[tbmc_pkg::FLAG_A_BIT]) begin
				flag_a_r <= 1'b0;
			end
			if (set_p) begin
				flag_p_r <= 1'b1;
			end else if (wr_acc && paddr == tbmc_pkg::OFS_FLAGS && pwdata[tbmc_pkg::FLAG_P_BIT]) begin
				flag_p_r <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	// Output pin
	assign pwm_lvl = ({1'b0, cnt_r} < duty) ? mode_r.output_initial_level :
	                 ~mode_r.output_initial_level; // see R8, R11

	always_comb begin
		pin_nxt = pin_r;
		case (mode_r.mode_select)
			tbmc_pkg::MODE_COMPARE: begin
				if (on_rise) begin
					pin_nxt = mode_r.output_initial_level; // see R7
				end else if (set_a) begin
					case (mode_r.pin_function)
						2'b00:   pin_nxt = pin_r; // see R3, R20
						2'b01:   pin_nxt = 1'b0; // see R3
						2'b10:   pin_nxt = 1'b1; // see R3
						default: pin_nxt = ~pin_r; // see R3
					endcase
				end
			end
			tbmc_pkg::MODE_PWM: begin
				case (mode_r.pin_function)
					2'b00:   pin_nxt = ~mode_r.output_initial_level; // see R4
					2'b01:   pin_nxt = mode_r.output_initial_level; // see R4
					2'b10:   pin_nxt = pwm_lvl; // see R4
					default: begin
						// Active while running; the A match stops the counter
						pin_nxt = (ctrl0_r.counter_on && !hw_stop) ?
						          mode_r.output_initial_level :
						          ~mode_r.output_initial_level; // see R4, R8
					end
				endcase
			end
			default: pin_nxt = pin_r; // see R10
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_r <= 1'b0;
			out_r <= 1'b0;
			oen_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
			if (mode_r.mode_select == tbmc_pkg::MODE_COMPARE ||
			    mode_r.mode_select == tbmc_pkg::MODE_PWM) begin
				out_r <= pin_nxt ^ mode_r.output_invert; // see R9
				oen_r <= 1'b1;
			end else begin
				out_r <= 1'b0; // see R10
				oen_r <= 1'b0;
			end
		end
	end

	assign timer_output_pin = out_r;
	assign timer_output_en  = oen_r;

endmodule

/* tbmc_timer_asserts.sv */
// Port checker for the ten-bit timer
`timescale 1ns/1ps
module tbmc_timer_asserts #(
	parameter int SUB_DIV = 64
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        capture_input_pin,
	input wire logic        internal_detector_output,
	input wire logic        timer_clock_pin,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_en
);
	logic [7:0] mode_r;
	logic       cap_r;
	logic       on_r;
	logic [1:0] stab_r;
	logic       wr_acc;
	assign wr_acc = psel && penable && pwrite && pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) mode_r <= 8'h00;
		else if (wr_acc && paddr == tbmc_pkg::OFS_MODE_CTRL) mode_r <= pwdata[7:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cap_r <= 1'b0;
		else if (wr_acc && paddr == tbmc_pkg::OFS_CAP_SEL) cap_r <= pwdata[7];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) on_r <= 1'b0;
		else if (wr_acc && paddr == tbmc_pkg::OFS_CONTROL0) on_r <= pwdata[3];
	end
	// Cycles since the last mode or control write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) stab_r <= 2'h0;
		else if (wr_acc && paddr inside {tbmc_pkg::OFS_MODE_CTRL, tbmc_pkg::OFS_CONTROL0})
			stab_r <= 2'h0;
		else if (stab_r != 2'h3) stab_r <= stab_r + 2'h1;
	end
	//////////////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_read(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a ##1 psel && penable;
	endsequence
	sequence s_on_rise;
		wr_acc && paddr == tbmc_pkg::OFS_CONTROL0 && pwdata[3] && !on_r && mode_r[7:6] == 2'b00;
	endsequence
	a_mode_readback: assert property (
		s_read(tbmc_pkg::OFS_MODE_CTRL) |-> prdata == {24'h000000, mode_r})
		else $error("mode register readback wrong");
	a_count_hi_zero: assert property (
		s_read(tbmc_pkg::OFS_COUNT_HIGH) |-> prdata[31:2] == 30'h00000000)
		else $error("counter high unused bits not zero");
	a_cmpa_hi_zero: assert property (
		s_read(tbmc_pkg::OFS_CMPA_HIGH) |-> prdata[31:2] == 30'h00000000)
		else $error("compare high unused bits not zero");
	a_cap_sel_read: assert property (
		s_read(tbmc_pkg::OFS_CAP_SEL) |-> prdata == {24'h000000, cap_r, 7'h00})
		else $error("capture select readback wrong");
	a_drive_en_on: assert property (
		stab_r == 2'h3 && !mode_r[6] |-> timer_output_en)
		else $error("output not driven in an output mode");
	a_no_drive_en: assert property (
		stab_r == 2'h3 && mode_r[6] |-> !timer_output_en)
		else $error("output driven in capture or timer mode");
	a_start_level: assert property (
		s_on_rise |-> ##[1:3] timer_output_pin == (mode_r[3] ^ mode_r[2]))
		else $error("initial level not applied at start");
	a_pwm_forced: assert property (
		stab_r == 2'h3 && on_r && mode_r[7:5] == 3'b100 |->
		timer_output_pin == ((mode_r[4] ? mode_r[3] : !mode_r[3]) ^ mode_r[2]))
		else $error("forced level wrong");
endmodule

bind tbmc_timer tbmc_timer_asserts #(.SUB_DIV(SUB_DIV)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.capture_input_pin(capture_input_pin), .internal_detector_output(internal_detector_output),
	.timer_clock_pin(timer_clock_pin), .timer_output_pin(timer_output_pin),
	.timer_output_en(timer_output_en)
);

/* tbmc_timer_tb.sv */
// Self-checking bench for the ten-bit timer
`timescale 1ns/1ps
module tbmc_timer_tb;
	localparam logic [7:0] a_c0 = tbmc_pkg::OFS_CONTROL0;
	localparam logic [7:0] a_mc = tbmc_pkg::OFS_MODE_CTRL;
	localparam logic [7:0] a_ch = tbmc_pkg::OFS_COUNT_HIGH;
	localparam logic [7:0] a_ah = tbmc_pkg::OFS_CMPA_HIGH;
	localparam logic [7:0] a_fl = tbmc_pkg::OFS_FLAGS;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_pin;
	logic        det;
	logic        tclk;
	logic        out_pin;
	logic        out_en;
	logic        out_wire;
	logic [31:0] r;
	logic        e;
	logic        lvl;
	logic        ex;
	logic [1:0]  fb;
	logic [9:0]  v;
	logic [9:0]  w;
	logic [7:0]  pm [5];
	logic [9:0]  cm [5];
	int          ph [5];
	int          n;
	int          miscompares;
	int          comparisons;

	tbmc_timer #(.SUB_DIV(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(cap_pin), .internal_detector_output(det), .timer_clock_pin(tclk),
		.timer_output_pin(out_pin), .timer_output_en(out_en)
	);
	tbmc_pins P (
		.pclk(pclk), .timer_output_pin(out_pin), .timer_output_en(out_en),
		.capture_input_pin(cap_pin), .internal_detector_output(det),
		.timer_clock_pin(tclk), .out_wire(out_wire)
	);

	initial pclk = 1'b0;
	always #4 pclk = ~pclk;
	//////////////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk_reg(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR t=%0t got %0h exp %0h", $time, g, x);
		end
	endtask
	task chk_pin(input logic g, input logic x);
		chk_reg({31'h00000000, g}, {31'h00000000, x});
	endtask
	task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			final_report;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd10(input logic [7:0] hi);
		xfer(1'b0, hi, 8'h00);
		v[9:8] = r[1:0];
		xfer(1'b0, hi - 8'h04, 8'h00);
		v[7:0] = r[7:0];
	endtask
	task wr10(input logic [7:0] hi, input logic [9:0] d);
		wr(hi - 8'h04, d[7:0]);
		wr(hi, {6'h00, d[9:8]});
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		final_report;
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		miscompares = 0;
		comparisons = 0;
		pm = '{8'hA9, 8'hA1, 8'hAF, 8'h89, 8'h99};
		cm = '{10'h020, 10'h020, 10'h0C8, 10'h020, 10'h020};
		ph = '{800, 2400, 1152, 0, 3200};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, 8'(i * 4), 8'h00);
			chk_reg(r, 32'h00000000);
		end
		xfer(1'b0, 8'h20, 8'h00);
		chk_pin(e, 1'b1);
		wr(a_mc, 8'hA5);
		xfer(1'b0, a_mc, 8'h00);
		chk_reg(r, 32'h000000A5);
		wr(a_mc, 8'h00);
		wr(tbmc_pkg::OFS_CAP_SEL, 8'hFF);
		xfer(1'b0, tbmc_pkg::OFS_CAP_SEL, 8'h00);
		chk_reg(r, 32'h00000080);
		wr10(a_ah, 10'h123);
		wr(tbmc_pkg::OFS_CMPA_LOW, 8'hAA);
		rd10(a_ah);
		chk_reg(32'(v), 32'h00000123);
		wr(a_ah, 8'hFE);
		rd10(a_ah);
		chk_reg(32'(v), 32'h00000223);
		wr(tbmc_pkg::OFS_COUNT_LOW, 8'hFF);
		rd10(a_ch);
		chk_reg(32'(v), 32'h00000000);
		$display("test registers done");
		for (int f = 0; f < 4; f++) begin
			fb = f[1:0];
			lvl = !fb[1];
			ex = (fb == 2'b00) ? lvl : (fb == 2'b11) ? !lvl : fb[1];
			wr(a_mc, {2'b00, fb, lvl, fb[0], 2'b01});
			wr10(a_ah, 10'h0C8);
			wr(a_fl, 8'h03);
			wr(a_c0, 8'h19);
			repeat (4) @(negedge pclk);
			chk_pin(out_pin, lvl ^ fb[0]);
			repeat (226) @(negedge pclk);
			chk_pin(out_pin, ex ^ fb[0]);
			xfer(1'b0, a_fl, 8'h00);
			chk_reg(r, 32'h00000001);
			wr(a_c0, 8'h11);
		end
		$display("test compare output done");
		wr(a_mc, 8'h30);
		wr10(a_ah, 10'h028);
		wr(a_fl, 8'h03);
		wr(a_c0, 8'h19);
		repeat (150) @(negedge pclk);
		chk_pin(out_pin, 1'b1);
		xfer(1'b0, a_fl, 8'h00);
		chk_reg(r, 32'h00000003);
		rd10(a_ch);
		chk_pin(v < 10'h040, 1'b1);
		wr(a_c0, 8'h10);
		wr10(a_ah, 10'h000);
		wr(a_fl, 8'h03);
		wr(a_c0, 8'h18);
		repeat (1100) @(negedge pclk);
		xfer(1'b0, a_fl, 8'h00);
		chk_reg(r, 32'h00000002);
		chk_pin(out_pin, 1'b0);
		wr(a_c0, 8'h10);
		rd10(a_ch);
		w = v;
		chk_pin(w inside {[10'h020:10'h07F]}, 1'b1);
		repeat (20) @(negedge pclk);
		rd10(a_ch);
		chk_reg(32'(v), 32'(w));
		wr(a_c0, 8'h18);
		rd10(a_ch);
		chk_pin(v < 10'h010, 1'b1);
		wr(a_c0, 8'h10);
		wr(a_mc, 8'hFC);
		wr10(a_ah, 10'h028);
		wr(a_fl, 8'h03);
		wr(a_c0, 8'h19);
		repeat (150) @(negedge pclk);
		chk_pin(out_wire, 1'b1);
		xfer(1'b0, a_fl, 8'h00);
		chk_reg(r, 32'h00000003);
		wr(a_c0, 8'h10);
		$display("test clear and overflow done");
		for (int i = 0; i < 5; i++) begin
			wr(a_mc, pm[i]);
			wr10(a_ah, cm[i]);
			wr(a_c0, 8'h19);
			repeat (20) @(negedge pclk);
			n = 0;
			for (int k = 0; k < 3200; k++) begin
				@(negedge pclk);
				if (out_pin === 1'b1) n++;
			end
			chk_reg(32'(n), 32'(ph[i]));
			wr(a_c0, 8'h11);
		end
		wr(a_mc, 8'hB9);
		wr10(a_ah, 10'h020);
		wr(a_c0, 8'h19);
		repeat (10) @(negedge pclk);
		chk_pin(out_pin, 1'b1);
		repeat (40) @(negedge pclk);
		chk_pin(out_pin, 1'b0);
		xfer(1'b0, a_c0, 8'h00);
		chk_reg(r, 32'h00000011);
		$display("test waveform done");
		for (int s = 0; s < 2; s++) begin
			for (int f = 0; f < 4; f++) begin
				fb = f[1:0];
				wr(tbmc_pkg::OFS_CAP_SEL, {s[0], 7'h00});
				wr(a_mc, {2'b01, fb, 4'h0});
				wr10(a_ah, 10'h000);
				wr(a_c0, 8'h18);
				P.drive(!s[0], 1'b1);
				repeat (20) @(negedge pclk);
				P.drive(!s[0], 1'b0);
				repeat (20) @(negedge pclk);
				chk_pin(out_wire, 1'b1);
				rd10(a_ah);
				chk_reg(32'(v), 32'h00000000);
				P.drive(s[0], 1'b1);
				repeat (20) @(negedge pclk);
				rd10(a_ah);
				w = v;
				chk_pin(w != 10'h000, !fb[0]);
				P.drive(s[0], 1'b0);
				repeat (20) @(negedge pclk);
				rd10(a_ah);
				chk_pin(v != w, fb == 2'b01 || fb == 2'b10);
				wr(a_c0, 8'h10);
			end
		end
		$display("test capture done");
		final_report;
	end
endmodule
